// File: bench/smp_monitor.sv
// Assertions on the wires between the SPI master and the device
`timescale 1ns/1ps
module smp_monitor (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    logic sck_d_r;
    logic sel_d_r;
    logic [3:0] since_r;
    logic [15:0] edges_r;

    // Cycles since the last link clock edge; saturates so long idle spans stay harmless
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
            since_r <= 4'hf;
            edges_r <= 16'h0000;
        end else begin
            sck_d_r <= sck;
            sel_d_r <= sel_n;
            since_r <= (sck != sck_d_r) ? 4'h0 : ((since_r == 4'hf) ? since_r : since_r + 4'h1);
            if (sel_n && sel_d_r) begin
                edges_r <= 16'h0000;
            end else if (sck != sck_d_r) begin
                edges_r <= edges_r + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    property p_oe_idle;
        sel_n [*4] |-> !miso_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");

    property p_oe_start;
        $fell(sel_n) |-> ##[1:9] miso_oe;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("miso not driven after select");

    property p_sck_setup;
        $fell(sel_n) |=> $stable(sck) [*8];
    endproperty
    a_sck_setup: assert property (p_sck_setup) else $error("clock moved too soon after select");

    property p_sel_gap;
        $rose(sel_n) |=> sel_n [*8];
    endproperty
    a_sel_gap: assert property (p_sel_gap) else $error("select gap too short");

    property p_sck_half;
        $changed(sck) && !sel_n |=> $stable(sck) [*7];
    endproperty
    a_sck_half: assert property (p_sck_half) else $error("clock half period too short");

    property p_frame_bits;
        $rose(sel_n) |-> edges_r[3:0] == 4'h0 && edges_r >= 16'h0040;
    endproperty
    a_frame_bits: assert property (p_frame_bits) else $error("message not whole bytes or short header");

    property p_miso_shift;
        !sel_n && miso_oe && $past(miso_oe, 2) && $changed(miso_o) |-> since_r <= 4'h5;
    endproperty
    a_miso_shift: assert property (p_miso_shift) else $error("miso changed away from a clock edge");

    property p_mosi_shift;
        !sel_n && !$past(sel_n) && $changed(mosi) |-> $changed(sck) || since_r <= 4'h1;
    endproperty
    a_mosi_shift: assert property (p_mosi_shift) else $error("mosi changed away from a clock edge");
endmodule

// File: bench/tb.sv
// Bench joining the SPI master and device ends over the link
`timescale 1ns/1ps
module tb import smp_pkg::*; ;
    logic sys_clk_i, resetn_i, start, wr_valid, brk, cmd_v, rd_pop, tx_take, rx_valid, busy, irq_o, sck_q, idle_sck;
    logic [1:0] mode;
    logic [7:0] cmd, tx_byte, rd_data, wr_data, dcmd, rx_byte;
    logic [23:0] param, dparam;
    logic [15:0] nbytes, rx_avail, tx_space, h_rx, h_tx;
    logic [31:0] mi_sh, mo_sh;
    logic [32:0] tab [10];
    logic [7:0] wq[$], rq[$];
    int n_errors, n_compared, n_brk, n_cv, nbits;

    smp_if spi();
    smp_device #(.CW(16)) smp_device_i(.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi(spi), .mode_i(mode),
        .rx_avail_i(rx_avail), .tx_space_i(tx_space), .rd_data_i(rd_data), .rd_pop_o(rd_pop), .wr_data_o(wr_data),
        .wr_valid_o(wr_valid), .break_o(brk), .cmd_o(dcmd), .param_o(dparam), .cmd_valid_o(cmd_v));
    smp_host #(.MAXB(16)) smp_host_i(.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .spi(spi), .mode_i(mode),
        .start_i(start), .cmd_i(cmd), .param_i(param), .nbytes_i(nbytes), .tx_byte_i(tx_byte), .tx_take_o(tx_take),
        .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .rx_avail_o(h_rx), .tx_space_o(h_tx), .busy_o(busy),
        .irq_o(irq_o));
    smp_monitor smp_monitor_i(.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sck(spi.sck), .sel_n(spi.sel_n),
        .mosi(spi.mosi), .miso_o(spi.miso_o), .miso_oe(spi.miso_oe));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    always @(negedge spi.sel_n) idle_sck = spi.sck;

    // Header bits are caught on the sampling edge of the selected mode, straight off the wires
    always @(posedge sys_clk_i) begin
        sck_q <= spi.sck;
        if (brk === 1'b1) n_brk++;
        if (cmd_v === 1'b1) n_cv++;
        if (wr_valid === 1'b1) wq.push_back(wr_data);
        if (rx_valid === 1'b1) rq.push_back(rx_byte);
        if (rd_pop === 1'b1) rd_data <= rd_data + 8'h11;
        if (tx_take === 1'b1) tx_byte <= tx_byte + 8'h22;
        if (spi.sel_n !== 1'b0) begin
            nbits <= 0;
        end else if (spi.sck !== sck_q && spi.sck === ^mode && nbits < 32) begin
            mi_sh <= {mi_sh[30:0], spi.miso};
            mo_sh <= {mo_sh[30:0], spi.mosi};
            nbits <= nbits + 1;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One whole message; every message also has its header checked on both ends
    task automatic msg(input logic [7:0] c, input logic [23:0] p, input logic [15:0] n);
        int k;
        wq.delete();
        rq.delete();
        n_brk = 0;
        n_cv = 0;
        @(posedge sys_clk_i);
        cmd <= c;
        param <= p;
        nbytes <= n;
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge sys_clk_i);
            k++;
        end while (busy !== 1'b0 && k < 4000);
        if (k >= 4000) begin
            n_errors++;
            final_report();
        end
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk(mi_sh, {rx_avail[7:0], rx_avail[15:8], tx_space[7:0], tx_space[15:8]});
        chk(mo_sh, {c, p});
        chk({h_rx, h_tx}, {rx_avail, tx_space});
        chk({dcmd, dparam}, {c, p});
        chk(idle_sck, mode[1]);
        chk(n_cv, 1);
        chk(n_brk, c == SMP_CMD_BREAK);
    endtask

    initial begin
        resetn_i = 1'b1;
        start = 1'b0;
        mode = SMP_MODE_DEFAULT;
        cmd = 8'h00;
        param = 24'h000000;
        nbytes = 16'h0000;
        tx_byte = 8'h00;
        rd_data = 8'h00;
        rx_avail = 16'h0000;
        tx_space = 16'h0000;
        n_errors = 0;
        n_compared = 0;
        // A real falling reset edge, so every flop is known before the first sampling edge
        #1 resetn_i = 1'b0;
        tab = '{{8'h10, 8'h81, 16'h0005, 1'b1},
                {8'h00, 8'h00, 16'h0000, 1'b0},
                {8'h10, 8'h02, 16'h0005, 1'b0},
                {8'h20, 8'h03, 16'h0005, 1'b1},
                {8'h10, 8'h82, 16'h0000, 1'b1},
                {8'h80, 8'h00, 16'h0000, 1'b0},
                {8'h10, 8'h82, 16'h0000, 1'b1},
                {8'h20, 8'h02, 16'h0000, 1'b0},
                {8'h10, 8'h82, 16'h0000, 1'b1},
                {8'h08, 8'h00, 16'h0000, 1'b0}};
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        #1;
        chk({spi.irq, spi.sel_n, busy}, 3'b110);
        for (int m = 0; m < 4; m++) begin
            mode <= m[1:0];
            rx_avail <= 16'h8001 ^ {m[7:0], m[7:0]};
            tx_space <= 16'hc0a0 + m[15:0];
            // Trailing-edge modes carry a non-zero header so a slipped bit shows
            msg(m[0] ? SMP_CMD_NO_ACTION : SMP_CMD_IRQ_DISABLE, m[0] ? 24'h000000 : 24'h030000, 16'h0000);
            chk(spi.irq, 1'b1);
        end
        $display("test modes done");
        msg(SMP_CMD_BREAK, 24'h000000, 16'h0000);
        $display("test break done");
        rd_data <= 8'h5a;
        rx_avail <= 16'h0002;
        msg(SMP_CMD_READ_HOST_DATA, 24'h000000, 16'h0002);
        chk(rq.size(), 2);
        chk({rq[0], rq[1]}, 16'h5a6b);
        $display("test read done");
        tx_byte <= 8'h10;
        tx_space <= 16'h0040;
        msg(SMP_CMD_WRITE_DEVICE_DATA, 24'h000000, 16'h0003);
        chk(wq.size(), 3);
        chk({wq[0], wq[1], wq[2]}, 24'h103254);
        $display("test write done");
        for (int i = 0; i < 10; i++) begin
            rx_avail <= tab[i][16:1];
            msg(tab[i][32:25], {tab[i][24:17], 16'h0000}, {15'h0000, tab[i][32:25] == SMP_CMD_WRITE_DEVICE_DATA});
            chk(spi.irq, tab[i][0]);
            chk(irq_o, tab[i][0]);
        end
        $display("test irq done");
        final_report();
    end
endmodule

// File: include/smp_if.sv
// Interface joining the SPI master and the device slave
`timescale 1ns/1ps
interface smp_if;
    logic sck;
    logic sel_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic irq;
    wire miso = miso_oe ? miso_o : 1'b0;
    modport device (input sck, input sel_n, input mosi, output miso_o, output miso_oe, output irq);
    modport host (output sck, output sel_n, output mosi, input miso, input irq);
endinterface

// File: include/smp_pkg.sv
// Shared constants and types for the SPI message protocol link
package smp_pkg;
    localparam int SMP_HDR_BYTES = 4;
    localparam logic [7:0] SMP_CMD_NO_ACTION = 8'h00;
    localparam logic [7:0] SMP_CMD_BREAK = 8'h04;
    localparam logic [7:0] SMP_CMD_CLEAR_TX_SPACE_IRQ = 8'h08;
    localparam logic [7:0] SMP_CMD_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] SMP_CMD_IRQ_DISABLE = 8'h20;
    localparam logic [7:0] SMP_CMD_READ_HOST_DATA = 8'h40;
    localparam logic [7:0] SMP_CMD_WRITE_DEVICE_DATA = 8'h80;
    localparam int SMP_BIT_POLARITY = 7;
    localparam int SMP_BIT_TX_IRQ = 1;
    localparam int SMP_BIT_RX_IRQ = 0;
    localparam logic [1:0] SMP_MODE_DEFAULT = 2'h0;
    localparam int SMP_SYS_CLK_MHZ = 100;
    localparam int SMP_SCK_HALF_NS = 80;
    localparam int SMP_SCK_HALF_CYC = (SMP_SCK_HALF_NS * SMP_SYS_CLK_MHZ + 999) / 1000;
    localparam int SMP_CS_SETUP_NS = 100;
    localparam int SMP_CS_SETUP_CYC = (SMP_CS_SETUP_NS * SMP_SYS_CLK_MHZ + 999) / 1000;
    localparam int SMP_CS_GAP_NS = 100;
    localparam int SMP_CS_GAP_CYC = (SMP_CS_GAP_NS * SMP_SYS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SMP_CNT_W = 8'h10;
    typedef enum logic [2:0] {SMP_H_IDLE, SMP_H_SETUP, SMP_H_LEAD, SMP_H_TRAIL, SMP_H_GAP} smp_host_state_t;
endpackage

// File: src/smp_device.sv
// SPI slave end: status header, command decode and interrupt line
//
`timescale 1ns/1ps
module smp_device import smp_pkg::*; #(
    parameter int CW = 16
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    smp_if.device spi,
    input wire logic [1:0] mode_i,
    input wire logic [CW-1:0] rx_avail_i,
    input wire logic [CW-1:0] tx_space_i,
    input wire logic [7:0] rd_data_i,
    output logic rd_pop_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o,
    output logic break_o,
    output logic [7:0] cmd_o,
    output logic [23:0] param_o,
    output logic cmd_valid_o
);
    if (CW != 16) begin
        $error("count width must be 16");
    end

    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] sel_s;
        logic [1:0] mosi_s;
        logic sck_d;
        logic [2:0] bitc;
        logic [15:0] bytec;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic [7:0] cmd;
        logic [23:0] param;
        logic [31:0] status;
        logic pol;
        logic en_tx;
        logic en_rx;
        logic tx_clr;
        logic miso;
        logic miso_oe;
        logic irq;
        logic rd_pop;
        logic [7:0] wr_data;
        logic wr_valid;
        logic brk;
        logic cmd_valid;
    } smp_dev_t;

    smp_dev_t s_r, s_nxt;

    always_comb begin
        logic sel;
        logic lead;
        logic trail;
        logic samp;
        logic shft;
        logic [7:0] byte_in;
        logic [7:0] nxt_byte;
        logic act;
        sel = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        samp = 1'b0;
        shft = 1'b0;
        byte_in = 8'h00;
        nxt_byte = 8'h00;
        act = 1'b0;
        s_nxt = s_r;
        s_nxt.sck_s = {s_r.sck_s[0], spi.sck};
        s_nxt.sel_s = {s_r.sel_s[0], spi.sel_n};
        s_nxt.mosi_s = {s_r.mosi_s[0], spi.mosi};
        s_nxt.sck_d = s_r.sck_s[1];
        s_nxt.rd_pop = 1'b0;
        s_nxt.wr_valid = 1'b0;
        s_nxt.brk = 1'b0;
        s_nxt.cmd_valid = 1'b0;
        sel = !s_r.sel_s[1];
        // Leading edge leaves idle level; CPOL is mode bit 1
        lead = (s_r.sck_s[1] != s_r.sck_d) && (s_r.sck_d == mode_i[1]);
        trail = (s_r.sck_s[1] != s_r.sck_d) && (s_r.sck_d != mode_i[1]);
        samp = mode_i[0] ? lead : trail;
        shft = mode_i[0] ? trail : lead;
        if (!sel) begin
            // Deselect restarts framing; a held select runs on
            s_nxt.bitc = 3'h0;
            s_nxt.bytec = 16'h0000;
            s_nxt.miso_oe = 1'b0;
            s_nxt.miso = 1'b0;
        end else begin
            s_nxt.miso_oe = 1'b1;
            if (s_r.sel_s[1] == 1'b0 && s_r.bytec == 16'h0000 && s_r.bitc == 3'h0 && !s_r.miso_oe) begin
                // Status laid out so bits go out rx low, rx high, tx low, tx high
                s_nxt.status = {rx_avail_i[7:0], rx_avail_i[15:8], tx_space_i[7:0], tx_space_i[15:8]};
                s_nxt.sh_out = rx_avail_i[7:0];
                s_nxt.miso = rx_avail_i[7];
            end
            if (samp) begin
                byte_in = {s_r.sh_in[6:0], s_r.mosi_s[1]};
                s_nxt.sh_in = byte_in;
                s_nxt.bitc = s_r.bitc + 3'h1;
                if (s_r.bitc == 3'h7) begin
                    s_nxt.bytec = s_r.bytec + 16'h0001;
                    unique case (s_r.bytec)
                        16'h0000: s_nxt.cmd = byte_in;
                        16'h0001: s_nxt.param[23:16] = byte_in;
                        16'h0002: s_nxt.param[15:8] = byte_in;
                        16'h0003: begin
                            s_nxt.param[7:0] = byte_in;
                            s_nxt.cmd_valid = 1'b1;
                            act = 1'b1;
                        end
                        default: begin
                            if (s_r.cmd == SMP_CMD_WRITE_DEVICE_DATA) begin
                                s_nxt.wr_data = byte_in;
                                s_nxt.wr_valid = 1'b1;
                                s_nxt.tx_clr = 1'b1;
                            end
                            if (s_r.cmd == SMP_CMD_READ_HOST_DATA) begin
                                s_nxt.rd_pop = 1'b1;
                            end
                        end
                    endcase
                end
            end
            if (shft && s_r.bitc == 3'h0 && s_r.bytec != 16'h0000) begin
                // New byte: header bytes from status, then read data
                if (s_r.bytec < 16'(SMP_HDR_BYTES)) begin
                    nxt_byte = s_r.status[31 - 8 * s_r.bytec[1:0] -: 8];
                end else if (s_r.cmd == SMP_CMD_READ_HOST_DATA) begin
                    nxt_byte = rd_data_i;
                end
                s_nxt.sh_out = nxt_byte;
                s_nxt.miso = nxt_byte[7];
            end else if (shft && s_r.bitc != 3'h0) begin
                // Top bit of the first byte stands from select; the edge before its sample must keep it
                s_nxt.sh_out = {s_r.sh_out[6:0], 1'b0};
                s_nxt.miso = s_r.sh_out[6];
            end
        end
        if (act) begin
            unique case (s_r.cmd)
                SMP_CMD_BREAK: s_nxt.brk = 1'b1;
                SMP_CMD_CLEAR_TX_SPACE_IRQ: s_nxt.tx_clr = 1'b1;
                SMP_CMD_IRQ_ENABLE: begin
                    s_nxt.pol = s_nxt.param[23 - 7 + SMP_BIT_POLARITY];
                    if (s_nxt.param[16 + SMP_BIT_TX_IRQ]) begin
                        s_nxt.en_tx = 1'b1;
                        s_nxt.tx_clr = 1'b0;
                    end
                    if (s_nxt.param[16 + SMP_BIT_RX_IRQ]) s_nxt.en_rx = 1'b1;
                end
                SMP_CMD_IRQ_DISABLE: begin
                    if (s_nxt.param[16 + SMP_BIT_TX_IRQ]) s_nxt.en_tx = 1'b0;
                    if (s_nxt.param[16 + SMP_BIT_RX_IRQ]) s_nxt.en_rx = 1'b0;
                end
                default: ;
            endcase
        end
        // Space that appears again after a clear re-arms only on a new empty-to-room change or an IRQ enable with the tx bit set
        if (tx_space_i == '0) s_nxt.tx_clr = 1'b0;
        s_nxt.irq = ((s_r.en_tx && tx_space_i != '0 && !s_r.tx_clr) || (s_r.en_rx && rx_avail_i != '0)) ~^ s_r.pol;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
            s_r.sck_s <= 2'h0;
            s_r.sel_s <= 2'h3;
            s_r.irq <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign spi.miso_o = s_r.miso;
    assign spi.miso_oe = s_r.miso_oe;
    assign spi.irq = s_r.irq;
    assign rd_pop_o = s_r.rd_pop;
    assign wr_data_o = s_r.wr_data;
    assign wr_valid_o = s_r.wr_valid;
    assign break_o = s_r.brk;
    assign cmd_o = s_r.cmd;
    assign param_o = s_r.param;
    assign cmd_valid_o = s_r.cmd_valid;
endmodule

// File: src/smp_host.sv
// SPI master end: frames one message per request from the user port
`timescale 1ns/1ps
module smp_host import smp_pkg::*; #(
    parameter int MAXB = 16
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    smp_if.host spi,
    input wire logic [1:0] mode_i,
    input wire logic start_i,
    input wire logic [7:0] cmd_i,
    input wire logic [23:0] param_i,
    input wire logic [15:0] nbytes_i,
    input wire logic [7:0] tx_byte_i,
    output logic tx_take_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic [15:0] rx_avail_o,
    output logic [15:0] tx_space_o,
    output logic busy_o,
    output logic irq_o
);
    if (MAXB < 1 || MAXB > 65531) begin
        $error("MAXB must lie between 1 and 65531");
    end

    typedef struct packed {
        smp_host_state_t st;
        logic [1:0] irq_s;
        logic [1:0] miso_s;
        logic [7:0] tmr;
        logic [2:0] bitc;
        logic [15:0] bytec;
        logic [15:0] total;
        logic [7:0] sh_out;
        logic [7:0] sh_in;
        logic [23:0] param;
        logic [7:0] cmd;
        logic [31:0] status;
        logic sck;
        logic sel_n;
        logic mosi;
        logic tx_take;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic [15:0] rx_avail;
        logic [15:0] tx_space;
        logic busy;
    } smp_host_t;

    smp_host_t h_r, h_nxt;

    function automatic logic [7:0] hdr_byte(input logic [7:0] c, input logic [23:0] p, input logic [1:0] i);
        hdr_byte = (i == 2'h0) ? c : p[23 - 8 * (i - 2'h1) -: 8];
    endfunction

    always_comb begin
        logic [7:0] inb;
        logic [7:0] nb;
        inb = 8'h00;
        nb = 8'h00;
        h_nxt = h_r;
        h_nxt.irq_s = {h_r.irq_s[0], spi.irq};
        h_nxt.miso_s = {h_r.miso_s[0], spi.miso};
        h_nxt.tx_take = 1'b0;
        h_nxt.rx_valid = 1'b0;
        h_nxt.tmr = h_r.tmr + 8'h01;
        unique case (h_r.st)
            SMP_H_IDLE: begin
                h_nxt.sck = mode_i[1];
                h_nxt.tmr = 8'h00;
                if (start_i) begin
                    h_nxt.cmd = cmd_i;
                    h_nxt.param = param_i;
                    // Data length is capped so one message never outgrows the user side
                    h_nxt.total = 16'(SMP_HDR_BYTES) + ((nbytes_i > 16'(MAXB)) ? 16'(MAXB) : nbytes_i);
                    h_nxt.sel_n = 1'b0;
                    h_nxt.busy = 1'b1;
                    h_nxt.bitc = 3'h0;
                    h_nxt.bytec = 16'h0000;
                    h_nxt.sh_out = {cmd_i[6:0], 1'b0};
                    h_nxt.mosi = cmd_i[7];
                    h_nxt.st = SMP_H_SETUP;
                end
            end
            SMP_H_SETUP: if (h_r.tmr == 8'(SMP_CS_SETUP_CYC - 1)) begin
                h_nxt.tmr = 8'h00;
                h_nxt.st = SMP_H_LEAD;
            end
            SMP_H_LEAD: if (h_r.tmr == 8'(SMP_SCK_HALF_CYC - 1)) begin
                h_nxt.tmr = 8'h00;
                h_nxt.sck = !mode_i[1];
                if (mode_i[0]) begin
                    h_nxt.sh_in = {h_r.sh_in[6:0], h_r.miso_s[1]};
                end
                // Trailing-edge sampling: data moves on the leading edge, the very first bit is out at select
                if (!mode_i[0] && (h_r.bitc != 3'h0 || h_r.bytec != 16'h0000)) begin
                    h_nxt.mosi = h_r.sh_out[7];
                    h_nxt.sh_out = {h_r.sh_out[6:0], 1'b0};
                end
                h_nxt.st = SMP_H_TRAIL;
            end
            SMP_H_TRAIL: if (h_r.tmr == 8'(SMP_SCK_HALF_CYC - 1)) begin
                h_nxt.tmr = 8'h00;
                h_nxt.sck = mode_i[1];
                inb = mode_i[0] ? h_r.sh_in : {h_r.sh_in[6:0], h_r.miso_s[1]};
                h_nxt.sh_in = inb;
                h_nxt.bitc = h_r.bitc + 3'h1;
                h_nxt.st = SMP_H_LEAD;
                if (h_r.bitc == 3'h7) begin
                    h_nxt.bytec = h_r.bytec + 16'h0001;
                    if (h_r.bytec < 16'(SMP_HDR_BYTES)) begin
                        h_nxt.status = {h_r.status[23:0], inb};
                    end else begin
                        h_nxt.rx_byte = inb;
                        h_nxt.rx_valid = 1'b1;
                    end
                    if (h_r.bytec == 16'(SMP_HDR_BYTES - 1)) begin
                        h_nxt.rx_avail = {h_nxt.status[23:16], h_nxt.status[31:24]};
                        h_nxt.tx_space = {h_nxt.status[7:0], h_nxt.status[15:8]};
                    end
                    if (h_r.bytec + 16'h0001 == h_r.total) begin
                        h_nxt.st = SMP_H_GAP;
                    end else begin
                        nb = (h_r.bytec + 16'h0001 < 16'(SMP_HDR_BYTES))
                            ? hdr_byte(h_r.cmd, h_r.param, 2'(h_r.bytec + 16'h0001)) : tx_byte_i;
                        h_nxt.tx_take = h_r.bytec + 16'h0001 >= 16'(SMP_HDR_BYTES);
                        h_nxt.sh_out = mode_i[0] ? {nb[6:0], 1'b0} : nb;
                        if (mode_i[0]) h_nxt.mosi = nb[7];
                    end
                end else if (mode_i[0]) begin
                    h_nxt.mosi = h_r.sh_out[7];
                    h_nxt.sh_out = {h_r.sh_out[6:0], 1'b0};
                end
            end
            SMP_H_GAP: begin
                h_nxt.sel_n = 1'b1;
                if (h_r.tmr == 8'(SMP_CS_GAP_CYC - 1)) begin
                    h_nxt.busy = 1'b0;
                    h_nxt.st = SMP_H_IDLE;
                end
            end
            default: h_nxt.st = SMP_H_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            h_r <= '0;
            h_r.st <= SMP_H_IDLE;
            h_r.sel_n <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign spi.sck = h_r.sck;
    assign spi.sel_n = h_r.sel_n;
    assign spi.mosi = h_r.mosi;
    assign tx_take_o = h_r.tx_take;
    assign rx_byte_o = h_r.rx_byte;
    assign rx_valid_o = h_r.rx_valid;
    assign rx_avail_o = h_r.rx_avail;
    assign tx_space_o = h_r.tx_space;
    assign busy_o = h_r.busy;
    assign irq_o = h_r.irq_s[1];
endmodule
